// [core/fer_pkg.sv]
// package of constants and types for the flash ecc error reporting block
// Summary of operation
// - local fast-path error raises integrity trap, no bus error
// - single crossbar read error returns bus error
// - burst crossbar read error forces transaction-id error
// - bus error always reaches requesting master
// - peripheral-bus burst error ends at bridge
// - bridge reports terminated error, alarm raised
// - every multi-bit error except data flash path errors enters tracking buffer until it holds 8
// - tracking buffer full sends alarm
// - security module errors: occurrence only, no details
// - data flash ecc control reads zero after boot
// - trap-disable zero: bus trap on data flash error, except bank1 reads while bank1 is reserved for the security module
package fer_pkg;

	// ************************************************************
	// register map (byte offsets on the ahb-lite bus)
	// ************************************************************
	localparam logic [7:0] FER_OFS_DFLASH_ECC_CONTROL = 8'h00;
	localparam logic [7:0] FER_OFS_STATUS              = 8'h04;
	localparam logic [7:0] FER_OFS_CLEAR               = 8'h08;
	localparam logic [7:0] FER_OFS_ENABLE              = 8'h0C;
	localparam logic [7:0] FER_OFS_CAPT_ADDR           = 8'h10;
	localparam logic [7:0] FER_OFS_CAPT_INFO           = 8'h14;
	localparam logic [7:0] FER_OFS_TRACK_COUNT         = 8'h18;

	// ************************************************************
	// reset values and field positions
	// ************************************************************
	localparam logic [31:0] FER_RST_DFLASH_ECC_CONTROL = 32'h0000_0000;
	localparam int          FER_ECC_TRAP_DISABLE_LSB            = 30;
	localparam logic [1:0]  FER_ECC_TRAP_DISABLE_RST            = 2'h0;
	localparam int          FER_TRACK_DEPTH            = 8;

	// status bit positions
	localparam int FER_ST_INTEG  = 0;
	localparam int FER_ST_BUSERR = 1;
	localparam int FER_ST_TIDERR = 2;
	localparam int FER_ST_BRIDGE = 3;
	localparam int FER_ST_FULL   = 4;
	localparam int FER_ST_DFLASH = 5;
	localparam int FER_NST       = 6;

	// ************************************************************
	// types
	// ************************************************************
	// access path of an erroneous read
	typedef enum logic [1:0] {
		FER_PATH_FAST  = 2'h0,
		FER_PATH_CROSSBAR_UNIT  = 2'h1,
		FER_PATH_PERIPH= 2'h2,
		FER_PATH_DFL   = 2'h3
	} fer_path_t;

	// answer given to the master
	typedef enum logic [2:0] {
		FER_RSP_NONE   = 3'h0,
		FER_RSP_PTRAP  = 3'h1,
		FER_RSP_DTRAP  = 3'h2,
		FER_RSP_BUSERR = 3'h3,
		FER_RSP_TIDERR = 3'h4
	} fer_rsp_t;

	// bus slave state
	typedef enum logic [1:0] {
		FER_BS_IDLE = 2'b00,
		FER_BS_DATA = 2'b01
	} fer_bs_t;

endpackage

// [core/fer_track_if.sv]
// interface between the router and the tracking buffer
`timescale 1ns/1ps
`default_nettype none
interface fer_track_if;
	logic        push;    // one error entered
	logic [31:0] addr;    // address of the error
	logic        full;    // buffer full level
	logic [3:0]  count;   // entries held
	logic        clear;   // software empties buffer
	modport router (output push, output addr, output clear,
		input full, input count);
	modport buffer (input push, input addr, input clear,
		output full, output count);
endinterface
`default_nettype wire

// [core/fer_track_buf.sv]
// multi-bit error tracking buffer with full flag
`timescale 1ns/1ps
`default_nettype none
module fer_track_buf #(
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// router side
	fer_track_if.buffer    trk
);
	import fer_pkg::*;

	// ************************************************************
	// storage
	// ************************************************************
	logic [31:0] mem_q [DEPTH];          // recorded error addresses
	logic [3:0]  cnt_q;                  // entries held
	logic [3:0]  cnt_d;
	logic        wr;
	logic [2:0]  wr_idx;                 // slot the next entry goes to

	// next count; a full buffer keeps its contents and ignores pushes
	always_comb begin
		// an error landing with the clear is kept: it starts the new fill
		wr     = trk.push && (trk.clear || (cnt_q < 4'(DEPTH)));
		wr_idx = trk.clear ? 3'h0 : cnt_q[2:0];
		cnt_d  = cnt_q;
		if (trk.clear) begin
			cnt_d = {3'h0, trk.push};
		end else if (wr) begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	// register count
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// memory write, no reset needed for data
	always_ff @(posedge hclk) begin
		if (wr) begin
			mem_q[wr_idx] <= trk.addr;
		end
	end

	assign trk.count = cnt_q;
	assign trk.full  = (cnt_q == 4'(DEPTH));
endmodule
`default_nettype wire

// [core/fer_router.sv]
// routes flash multi-bit ecc errors to the reading master and raises alarms
//
// The register offsets and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fer_router (
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [7:0]         haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// flash read completion with error report
	input  wire logic               rd_valid,
	input  wire logic               rd_mbe,
	input  wire fer_pkg::fer_path_t rd_path,
	input  wire logic               rd_burst,
	input  wire logic               rd_ifetch,
	input  wire logic               rd_secmod,
	input  wire logic               rd_dfl_bank1,
	input  wire logic               dfl_bank1_secmod,
	input  wire logic [31:0]        rd_addr,
	input  wire logic [31:0]        rd_data,
	// answer to the master, same cycle group as data
	output logic                    rsp_valid,
	output logic [31:0]             rsp_data,
	output fer_pkg::fer_rsp_t       rsp_kind,
	// alarms to the safety management unit
	output logic                    alarm_track_full,
	output logic                    alarm_bus_event,
	// interrupt
	output logic                    irq
);
	import fer_pkg::*;

	// ************************************************************
	// signals
	// ************************************************************
	fer_track_if trk ();                       // tracking buffer link
	logic [31:0] ctrl_q, ctrl_d;               // dflash ecc control
	logic [FER_NST-1:0] st_q, st_d;            // sticky status
	logic [FER_NST-1:0] en_q, en_d;            // interrupt enable
	logic [FER_NST-1:0] ev;                    // events this cycle
	logic [31:0] capt_addr_q, capt_addr_d;     // captured address
	logic [31:0] capt_info_q, capt_info_d;     // captured details
	logic        rsp_valid_d;
	logic [31:0] rsp_data_d;
	fer_rsp_t    rsp_kind_q, rsp_kind_d;
	logic        full_q, full_d;               // full level, delayed
	logic        afull_d, abus_d, irq_d;
	// bus slave
	fer_bs_t     bs_q, bs_d;
	logic        wr_q, wr_d;
	logic [7:0]  ad_q, ad_d;
	logic [31:0] hrdata_d;
	logic        track_clr;
	logic [1:0]  ecc_trap_disable;

	// ************************************************************
	// tracking buffer
	// ************************************************************
	fer_track_buf #(.DEPTH(FER_TRACK_DEPTH)) u_trk (
		.hclk    (hclk),
		.hresetn (hresetn),
		.trk     (trk)
	);

	assign ecc_trap_disable   = ctrl_q[FER_ECC_TRAP_DISABLE_LSB +: 2];
	assign trk.push  = rd_valid && rd_mbe && (rd_path != FER_PATH_DFL);
	assign trk.addr  = rd_addr;
	assign trk.clear = track_clr;

	// ************************************************************
	// error routing
	// ************************************************************
	// decides the answer that goes out with the read data itself
	always_comb begin
		rsp_valid_d = rd_valid;
		rsp_data_d  = rd_data;
		rsp_kind_d  = FER_RSP_NONE;
		ev          = '0;
		if (rd_valid && rd_mbe) begin
			case (rd_path)
				FER_PATH_FAST: begin
					// no bus involved, so only a trap
					rsp_kind_d = rd_ifetch ? FER_RSP_PTRAP : FER_RSP_DTRAP;
					ev[FER_ST_INTEG] = 1'b1;
				end
				FER_PATH_CROSSBAR_UNIT: begin
					if (rd_burst) begin
						rsp_kind_d = FER_RSP_TIDERR;
						ev[FER_ST_TIDERR] = 1'b1;
					end else begin
						rsp_kind_d = FER_RSP_BUSERR;
						ev[FER_ST_BUSERR] = 1'b1;
					end
				end
				FER_PATH_PERIPH: begin
					if (rd_burst) begin
						// id error stops at the bridge; master sees data only
						rsp_kind_d = FER_RSP_NONE;
						ev[FER_ST_BRIDGE] = 1'b1;
					end else begin
						// single transfers, as the debug master uses
						rsp_kind_d = FER_RSP_BUSERR;
						ev[FER_ST_BUSERR] = 1'b1;
					end
				end
				FER_PATH_DFL: begin
					// trap only when trap-disable is clear and bank allowed
					if (ecc_trap_disable == FER_ECC_TRAP_DISABLE_RST &&
					    !(rd_dfl_bank1 && dfl_bank1_secmod)) begin
						rsp_kind_d = FER_RSP_BUSERR;
						ev[FER_ST_DFLASH] = 1'b1;
					end
				end
				default: rsp_kind_d = FER_RSP_NONE;
			endcase
		end
		// alarm on the rising edge of full only
		full_d  = trk.full;
		ev[FER_ST_FULL] = trk.full && !full_q;
		afull_d = trk.full && !full_q;
		abus_d  = ev[FER_ST_BRIDGE];
	end

	// capture registers; security module leaves details out
	always_comb begin
		capt_addr_d = capt_addr_q;
		capt_info_d = capt_info_q;
		if (rd_valid && rd_mbe) begin
			if (rd_secmod) begin
				capt_info_d = {31'h0, 1'b1};
			end else begin
				capt_addr_d = rd_addr;
				// bit0 valid, bits3:1 kind, bit4 burst, bit5 ifetch
				capt_info_d = {26'h0, rd_ifetch, rd_burst,
					rsp_kind_d, 1'b1};
			end
		end
	end

	// ************************************************************
	// ahb-lite slave
	// ************************************************************
	// zero wait states; write data lands in the data phase
	always_comb begin
		bs_d      = FER_BS_IDLE;
		wr_d      = 1'b0;
		ad_d      = ad_q;
		ctrl_d    = ctrl_q;
		en_d      = en_q;
		track_clr = 1'b0;
		st_d      = st_q;
		if (hsel && hready && htrans[1]) begin
			bs_d = FER_BS_DATA;
			wr_d = hwrite;
			ad_d = haddr;
		end
		if (bs_q == FER_BS_DATA && wr_q) begin
			case (ad_q)
				FER_OFS_DFLASH_ECC_CONTROL: ctrl_d = hwdata;
				FER_OFS_ENABLE: en_d = hwdata[FER_NST-1:0];
				FER_OFS_CLEAR: begin
					st_d = st_q & ~hwdata[FER_NST-1:0];
					track_clr = hwdata[FER_ST_FULL];
				end
				default: ctrl_d = ctrl_q;
			endcase
		end
		// set wins over clear
		st_d  = st_d | ev;
		irq_d = |(st_d & en_d);
	end

	// read data for the next data phase
	always_comb begin
		hrdata_d = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			case (haddr)
				FER_OFS_DFLASH_ECC_CONTROL: hrdata_d = ctrl_d;
				FER_OFS_STATUS:      hrdata_d = 32'(st_d);
				FER_OFS_ENABLE:      hrdata_d = 32'(en_d);
				FER_OFS_CAPT_ADDR:   hrdata_d = capt_addr_d;
				FER_OFS_CAPT_INFO:   hrdata_d = capt_info_d;
				FER_OFS_TRACK_COUNT: hrdata_d = {28'h0, trk.count};
				default:             hrdata_d = 32'h0000_0000;
			endcase
		end
	end

	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q           <= FER_RST_DFLASH_ECC_CONTROL;
			st_q             <= '0;
			en_q             <= '0;
			capt_addr_q      <= 32'h0000_0000;
			capt_info_q      <= 32'h0000_0000;
			rsp_valid        <= 1'b0;
			rsp_data         <= 32'h0000_0000;
			rsp_kind_q       <= FER_RSP_NONE;
			full_q           <= 1'b0;
			alarm_track_full <= 1'b0;
			alarm_bus_event  <= 1'b0;
			irq              <= 1'b0;
			bs_q             <= FER_BS_IDLE;
			wr_q             <= 1'b0;
			ad_q             <= 8'h00;
			hrdata           <= 32'h0000_0000;
		end else begin
			ctrl_q           <= ctrl_d;
			st_q             <= st_d;
			en_q             <= en_d;
			capt_addr_q      <= capt_addr_d;
			capt_info_q      <= capt_info_d;
			rsp_valid        <= rsp_valid_d;
			rsp_data         <= rsp_data_d;
			rsp_kind_q       <= rsp_kind_d;
			full_q           <= full_d;
			alarm_track_full <= afull_d;
			alarm_bus_event  <= abus_d;
			irq              <= irq_d;
			bs_q             <= bs_d;
			wr_q             <= wr_d;
			ad_q             <= ad_d;
			hrdata           <= hrdata_d;
		end
	end

	assign rsp_kind  = rsp_kind_q;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
endmodule
`default_nettype wire

// [tb/fer_flash_src.sv]
// flash read source standing in for the masters that read flash
`timescale 1ns/1ps
`default_nettype none
module fer_flash_src (
	// clock
	input  wire logic          hclk,
	// request from the bench
	input  wire logic          go,
	input  wire logic [7:0]    ctl,
	input  wire logic [31:0]   ra,
	input  wire logic [31:0]   rdd,
	// completion toward the router
	output logic               rd_valid,
	output logic               rd_mbe,
	output fer_pkg::fer_path_t rd_path,
	output logic               rd_burst,
	output logic               rd_ifetch,
	output logic               rd_secmod,
	output logic               rd_dfl_bank1,
	output logic [31:0]        rd_addr,
	output logic [31:0]        rd_data
);
	import fer_pkg::*;
	// one completion a request; data churns between completions
	// so that a stale word can never pass for a fresh one
	always_ff @(posedge hclk) begin
		rd_valid <= go;
		{rd_dfl_bank1, rd_secmod, rd_ifetch, rd_burst, rd_mbe} <= ctl[6:2];
		rd_path <= fer_path_t'(ctl[1:0]);
		// debug master acting for a tool issues single reads only
		if (ctl[7]) begin
			rd_burst <= 1'b0;
		end
		rd_addr <= ra;
		rd_data <= go ? rdd : ~rd_data;
	end
endmodule
`default_nettype wire

// [tb/fer_router_asserts.sv]
// concurrent checks on the ports of the flash ecc error router
`timescale 1ns/1ps
`default_nettype none
module fer_router_asserts
	import fer_pkg::*;
(
	// clock and reset
	input wire logic               hclk,
	input wire logic               hresetn,
	// flash completion
	input wire logic               rd_valid,
	input wire logic               rd_mbe,
	input wire fer_pkg::fer_path_t rd_path,
	input wire logic               rd_burst,
	input wire logic               rd_ifetch,
	// answer and alarms
	input wire logic               rsp_valid,
	input wire fer_pkg::fer_rsp_t  rsp_kind,
	input wire logic               alarm_bus_event,
	input wire logic               alarm_track_full
);
	// ************
	// helpers
	// ************
	logic e; // multi-bit error on a completing read
	assign e = rd_valid & rd_mbe;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ans_follow_a: assert property (rd_valid |=> rsp_valid)
		else $error("no answer after read");
	no_extra_a: assert property (!rd_valid |=> !rsp_valid)
		else $error("answer without read");
	fast_ptrap_a: assert property (e && rd_path == FER_PATH_FAST
		&& rd_ifetch |=> rsp_kind == FER_RSP_PTRAP)
		else $error("fast fetch error not a program trap");
	fast_dtrap_a: assert property (e && rd_path == FER_PATH_FAST
		&& !rd_ifetch |=> rsp_kind == FER_RSP_DTRAP)
		else $error("fast data error not a data trap");
	single_buserr_a: assert property (e && rd_path == FER_PATH_CROSSBAR_UNIT
		&& !rd_burst |=> rsp_kind == FER_RSP_BUSERR)
		else $error("single read error not a bus error");
	burst_tid_a: assert property (e && rd_path == FER_PATH_CROSSBAR_UNIT
		&& rd_burst |=> rsp_kind == FER_RSP_TIDERR)
		else $error("burst read error not an id error");
	periph_burst_a: assert property (e && rd_path == FER_PATH_PERIPH
		&& rd_burst |=> rsp_kind == FER_RSP_NONE && alarm_bus_event)
		else $error("peripheral burst error mishandled");
	bus_alarm_a: assert property (alarm_bus_event |->
		$past(e && rd_path == FER_PATH_PERIPH && rd_burst))
		else $error("bus event alarm without cause");
	full_cause_a: assert property (alarm_track_full |->
		$past(e) || $past(e, 2))
		else $error("full alarm without error");
	cover property (e && rd_path == FER_PATH_PERIPH && rd_burst);
	cover property (e && rd_path == FER_PATH_CROSSBAR_UNIT && rd_burst);
	cover property (alarm_track_full);
endmodule
bind fer_router fer_router_asserts fer_router_asserts_i (.hclk, .hresetn,
	.rd_valid, .rd_mbe, .rd_path, .rd_burst, .rd_ifetch, .rsp_valid,
	.rsp_kind, .alarm_bus_event, .alarm_track_full);
`default_nettype wire

// [tb/flash_ecc_error_reporting_tb_top.sv]
// self-checking bench for the flash ecc error router
`timescale 1ns/1ps
`default_nettype none
module flash_ecc_error_reporting_tb_top;
	import fer_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0;
	logic [7:0] haddr = 8'h00, ctl = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, ra = 32'h0, rdd = 32'h0, v, d = 32'h0AAE;
	logic [31:0] hrdata, rd_addr, rd_data, rsp_data;
	logic hreadyout, hresp, rd_valid, rd_mbe, rd_burst, rd_ifetch, rd_secmod;
	logic rd_dfl_bank1, rsp_valid, alarm_track_full, alarm_bus_event, irq;
	fer_path_t rd_path;
	fer_rsp_t rsp_kind;
	int miscompares = 0, cmp_count = 0, nfull = 0, nbus = 0, nberr = 0;
	logic bank1_sec = 1'b0; // data flash bank1 reserved for security module
	logic [34:0] exp_q [$];
	logic [34:0] ex;
	// {answer, dbg bank1 secmod ifetch burst mbe path}
	logic [10:0] tbl [10] = '{{FER_RSP_PTRAP, 8'h14}, {FER_RSP_DTRAP, 8'h04},
		{FER_RSP_BUSERR, 8'h05}, {FER_RSP_TIDERR, 8'h0D},
		{FER_RSP_NONE, 8'h0E}, {FER_RSP_BUSERR, 8'h06},
		{FER_RSP_BUSERR, 8'h8E}, {FER_RSP_BUSERR, 8'h07},
		{FER_RSP_BUSERR, 8'h47}, {FER_RSP_NONE, 8'h01}};
	always #2.5 hclk = ~hclk;
	fer_flash_src fer_flash_src_i (.*);
	fer_router fer_router_i (.*, .hready(hreadyout),
		.dfl_bank1_secmod(bank1_sec));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// one ahb-lite single word transfer, zero or more waits
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		v = hrdata;
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, v, e);
	endtask
	// one flash completion; go stays up until idle lowers it
	task automatic fl(input logic [7:0] c, input fer_rsp_t k);
		d = lfsr(d);
		go <= 1'b1;
		ctl <= c;
		rdd <= d;
		ra <= ~d;
		exp_q.push_back({k, d});
		@(posedge hclk);
	endtask
	task automatic idle(input int n);
		go <= 1'b0;
		repeat (n) @(posedge hclk);
	endtask
	task automatic complete_run;
		if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// monitor: answers against the oldest note, alarm pulses counted
	always @(posedge hclk) begin
		if (alarm_track_full === 1'b1) nfull++;
		if (alarm_bus_event === 1'b1) nbus++;
		// core and dma masters take an id error as a bus error
		if (rsp_valid === 1'b1 && (rsp_kind === FER_RSP_BUSERR ||
			rsp_kind === FER_RSP_TIDERR)) nberr++;
		if (rsp_valid === 1'b1) begin
			ex = exp_q.size() ? exp_q.pop_front() : 35'h7_FFFF_FFFF;
			chk("kind", 32'(rsp_kind), 32'(ex[34:32]));
			chk("data", rsp_data, ex[31:0]);
		end
	end
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		complete_run;
	end
	// ************
	// main sequence
	// ************
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk("control", FER_OFS_DFLASH_ECC_CONTROL, 32'h0);
		rchk("unmapped", 8'hFC, 32'h0);
		for (int i = 0; i < 10; i++) fl(tbl[i][7:0], fer_rsp_t'(tbl[i][10:8]));
		idle(4);
		chk("irq", 32'(irq), 32'h0);
		rchk("count", FER_OFS_TRACK_COUNT, 32'h7);
		chk("full alarms", nfull, 0);
		chk("bus alarms", nbus, 1);
		repeat (2) fl(8'h0D, FER_RSP_TIDERR);
		idle(4);
		rchk("count", FER_OFS_TRACK_COUNT, 32'h8);
		chk("full alarms", nfull, 1);
		bus(1'b1, FER_OFS_CLEAR, 32'h10);
		rchk("count", FER_OFS_TRACK_COUNT, 32'h0);
		bus(1'b1, FER_OFS_ENABLE, 32'h4);
		idle(2);
		chk("irq", 32'(irq), 32'h1);
		bus(1'b1, FER_OFS_ENABLE, 32'h0);
		idle(2);
		chk("irq", 32'(irq), 32'h0);
		bus(1'b1, FER_OFS_ENABLE, 32'h4);
		bus(1'b1, FER_OFS_CLEAR, 32'h3F);
		idle(2);
		chk("irq", 32'(irq), 32'h0);
		rchk("status", FER_OFS_STATUS, 32'h0);
		fl(8'h0D, FER_RSP_TIDERR);
		idle(3);
		chk("irq", 32'(irq), 32'h1);
		bank1_sec <= 1'b1;
		fl(8'h47, FER_RSP_NONE);
		fl(8'h07, FER_RSP_BUSERR);
		idle(3);
		bank1_sec <= 1'b0;
		bus(1'b1, FER_OFS_DFLASH_ECC_CONTROL, 32'hC000_0000);
		rchk("control", FER_OFS_DFLASH_ECC_CONTROL, 32'hC000_0000);
		fl(8'h07, FER_RSP_NONE);
		idle(3);
		chk("pending", exp_q.size(), 32'h0);
		chk("bus errors", nberr, 10);
		complete_run;
	end
endmodule
`default_nettype wire
